/* File: hw/orl_consts.svh */
/*
  Register offsets, reset values, field positions and codes for the
  over-range, init-status and power-setting register group.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef ORL_CONSTS_SVH
`define ORL_CONSTS_SVH

// Register offsets (15-bit register address space)
`define ORL_ADDR_OVR_THRESHOLD 15'h0211
`define ORL_ADDR_OVR_CONFIG 15'h0213
`define ORL_ADDR_INIT_STATUS 15'h0270
`define ORL_ADDR_POWER_TWO 15'h029A
`define ORL_ADDR_POWER_THREE 15'h029B
`define ORL_ADDR_POWER_FOUR 15'h029C

// Reset values
`define ORL_RST_OVR_THRESHOLD 8'hF2
`define ORL_RST_OVR_CONFIG 8'h07
`define ORL_RST_POWER_TWO 8'h0F
`define ORL_RST_POWER_THREE 8'h04
`define ORL_RST_POWER_FOUR 8'h1B

// Over-range configuration fields
`define ORL_CFG_EN_BIT 3
`define ORL_CFG_EXT_MSB 2
`define ORL_CFG_EXT_LSB 0
`define ORL_CFG_RSVD_MASK 8'hF0

// Power setting codes
`define ORL_P2_LOW 8'h06
`define ORL_P2_HIGH 8'h0F
`define ORL_P3_LOW 8'h00
`define ORL_P3_HIGH 8'h04
`define ORL_P4_LOW 8'h14
`define ORL_P4_HIGH 8'h1B

// Pulse stretch base: 4 sampling cycles times two to the field
`define ORL_EXT_BASE 4
// Default number of cycles of internal initialisation
`define ORL_INIT_CYCLES 64

`endif

/* File: hw/orl_device.sv */
/*
  Converter end: over-range threshold and pulse stretch, init status,
  and power setting registers on a simple strobe register port.
  Holds the over-range threshold and configuration, the read-only
  init-complete flag and the three power setting registers, and drives
  one stretched over-range pin per channel.
  Reserved power codes are stored and read back unchanged; the mode
  output then reports mixed until all three hold matching codes.
  Assumes samples arrive one per sampling-cycle enable on mclk.
  Assumes the host end raises one strobe per access, holds addr and
  wdata with it, and takes read data on the rdValid pulse.
  Assumes reset is held low for at least one mclk edge.
  Assumes orl_consts.svh on the include path.
*/
// Functional notes
// R1: Over-range asserts when level reaches threshold
// R2: Pins driven only while enable bit set
// R3: Pulse stretched to 4 times two^field cycles
// R4: Host rewrites reserved config bits as default
// R5: Init-complete bit reads one after initialisation
// R6: Host waits for init-complete before accessing
// R7: Setting two codes 0x06 low, 0x0F high
// R8: Setting three codes 0x00 low, 0x04 high
// R9: Setting four codes 0x14 low, 0x1B high
// R10: Host writes all power settings together
// R11: Host calibrates after changing operating mode
// R12: Host clears calibration and link first
// R13: Per-channel magnitude compare, greater or equal
`timescale 1ns/100ps
`default_nettype none
`include "orl_consts.svh"

module orl_device
	import orl_pkg::*;
#(
	parameter int SAMPLE_W = 9,
	parameter int CHANNELS = 4,
	parameter int INIT_CYCLES = `ORL_INIT_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	orl_if.device regs,
	// Samples, two's complement, one set per sampling enable
	input wire logic sampleEn,
	input wire logic [CHANNELS*SAMPLE_W-1:0] samples,
	// Over-range pins
	output logic [CHANNELS-1:0] overrangeOut,
	// Mode seen by analog core
	output orl_mode_t powerMode
);

	////////////////////////////////////////////////////////////////////////
	// Magnitude of a signed sample scaled to 8 bits
	// Keeps the top eight magnitude bits, so wider samples lose LSBs
	function automatic logic [7:0] mag8(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] a;
		a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
		// Full scale negative folds to the top code
		if (a[SAMPLE_W-1])
			mag8 = 8'hFF;
		else
			mag8 = 8'(a[SAMPLE_W-2:0] >> (SAMPLE_W-9));
	endfunction : mag8

	////////////////////////////////////////////////////////////////////////
	// Host-visible registers
	logic [7:0] thresholdQ;
	logic [7:0] configQ;
	logic [7:0] power2Q;
	logic [7:0] power3Q;
	logic [7:0] power4Q;

	// Internal state and read path
	logic initDoneQ;
	logic [$clog2(INIT_CYCLES+1)-1:0] initCntQ;
	logic [7:0] rdataQ;
	logic rdValidQ;

	// Address decode
	wire hitThr = regs.addr == `ORL_ADDR_OVR_THRESHOLD;
	wire hitCfg = regs.addr == `ORL_ADDR_OVR_CONFIG;
	wire hitInit = regs.addr == `ORL_ADDR_INIT_STATUS;
	wire hitP2 = regs.addr == `ORL_ADDR_POWER_TWO;
	wire hitP3 = regs.addr == `ORL_ADDR_POWER_THREE;
	wire hitP4 = regs.addr == `ORL_ADDR_POWER_FOUR;
	// Writes before init done are dropped; the host should not send them
	wire wrOk = regs.wrEn && initDoneQ; // R6
	// Per-register write enables, one decode each
	wire wrThr = wrOk && hitThr;
	wire wrCfg = wrOk && hitCfg;
	wire wrP2 = wrOk && hitP2;
	wire wrP3 = wrOk && hitP3;
	wire wrP4 = wrOk && hitP4;

	// Read mux; unmapped addresses read zero
	wire [7:0] rdMux = hitThr ? thresholdQ :
		hitCfg ? configQ :
		hitInit ? {7'h00, initDoneQ} : // R5
		hitP2 ? power2Q :
		hitP3 ? power3Q :
		hitP4 ? power4Q : 8'h00;

	// Over-range threshold and configuration
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			thresholdQ <= `ORL_RST_OVR_THRESHOLD;
			configQ <= `ORL_RST_OVR_CONFIG;
		end else begin
			if (wrThr) thresholdQ <= regs.wdata; // R1
			if (wrCfg) configQ <= regs.wdata;
		end
	end

	// Power setting group; reserved codes are stored as written
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			power2Q <= `ORL_RST_POWER_TWO;
			power3Q <= `ORL_RST_POWER_THREE;
			power4Q <= `ORL_RST_POWER_FOUR;
		end else begin
			if (wrP2) power2Q <= regs.wdata; // R7
			if (wrP3) power3Q <= regs.wdata; // R8
			if (wrP4) power4Q <= regs.wdata; // R9
		end
	end

	// Read data one cycle after the strobe
	// Registered, so rdata holds still while addr moves between reads
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdataQ <= 8'h00;
			rdValidQ <= 1'b0;
		end else begin
			rdValidQ <= regs.rdEn;
			if (regs.rdEn) rdataQ <= rdMux;
		end
	end
	assign regs.rdata = rdataQ;
	assign regs.rdValid = rdValidQ;

	////////////////////////////////////////////////////////////////////////
	// Initialisation counter; reads stay legal throughout
	// The counter freezes once done, so the flag cannot fall again
	// without a reset, and a poll that sees one may trust it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			initCntQ <= '0;
			initDoneQ <= 1'b0;
		end else if (!initDoneQ) begin
			initCntQ <= initCntQ + 1'b1;
			initDoneQ <= initCntQ == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1); // R5
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decode; mixed whenever the three settings are not all low or all high codes
	// Per-register code match; reserved codes match neither
	// Setting one lives outside this group and is not decoded here
	wire p2Low = power2Q == `ORL_P2_LOW; // R7
	wire p2High = power2Q == `ORL_P2_HIGH; // R7
	wire p3Low = power3Q == `ORL_P3_LOW; // R8
	wire p3High = power3Q == `ORL_P3_HIGH; // R8
	wire p4Low = power4Q == `ORL_P4_LOW; // R9
	wire p4High = power4Q == `ORL_P4_HIGH; // R9
	wire allLow = p2Low && p3Low && p4Low; // R7 R8 R9
	wire allHigh = p2High && p3High && p4High; // R7 R8 R9
	assign powerMode = allLow ? ORL_MODE_LOW : allHigh ? ORL_MODE_HIGH : ORL_MODE_MIXED;

	////////////////////////////////////////////////////////////////////////
	// Over-range detect and stretch per channel
	wire ovrEnable = configQ[`ORL_CFG_EN_BIT];
	wire [2:0] extField = configQ[`ORL_CFG_EXT_MSB:`ORL_CFG_EXT_LSB];
	// Hold length 4 << field, at most 512 sampling cycles
	wire [9:0] holdLen = 10'(`ORL_EXT_BASE) << extField; // R3

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : gChan
			logic [9:0] holdQ;
			logic pinQ;
			wire [7:0] mag = mag8(samples[ch*SAMPLE_W +: SAMPLE_W]);
			// Compare on the scaled magnitude, so both signs trip at one level
			wire hit = mag >= thresholdQ; // R1 R13
			// Count restarts on each hit, so the pin drops holdLen cycles after the last one
			// Back-to-back overloads give one long pulse, never a gap between them
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					holdQ <= 10'h000;
				else if (sampleEn && hit)
					holdQ <= holdLen; // R3
				else if (sampleEn && holdQ != 10'h000)
					holdQ <= holdQ - 1'b1;
			end
			// Detection keeps running when disabled; only the pin is held low
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n)
					pinQ <= 1'b0;
				else
					pinQ <= ovrEnable && (holdQ != 10'h000 || (sampleEn && hit)); // R2
			end
			assign overrangeOut[ch] = pinQ;
		end
	endgenerate

endmodule : orl_device

`default_nettype wire

/* File: hw/orl_host.sv */
/*
  Host end: waits for init complete, then runs user register accesses
  and whole-group power mode changes through the register port.
  Assumes the device end answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "orl_consts.svh"

module orl_host
	import orl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	orl_if.host regs,
	// Single access request
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [14:0] reqAddr,
	input wire logic [7:0] reqData,
	output logic reqReady,
	output logic [7:0] rspData,
	output logic rspValid,
	// Power mode change: 1 low power, 0 high performance
	input wire logic modeReq,
	input wire logic modeLow,
	// Calibration and serial link enables owned by the host
	output logic calEnable,
	output logic serialLinkEnable,
	input wire logic calEnableReq,
	input wire logic linkEnableReq,
	// Calibration needed after a mode change
	output logic calNeeded,
	input wire logic calDone,
	output logic initSeen
);

	orl_hstate_t stateQ, stateD;
	logic lowQ;
	logic pollQ;
	logic [7:0] rspDataQ;
	logic rspValidQ;
	logic calNeededQ;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		stateD = stateQ;
		unique case (stateQ)
			ORL_H_WAITINIT: if (regs.rdValid && regs.rdata[0]) stateD = ORL_H_IDLE; // R6
			ORL_H_IDLE: begin
				if (modeReq) stateD = ORL_H_QUIESCE;
				else if (reqValid) stateD = ORL_H_SINGLE;
			end
			ORL_H_QUIESCE: stateD = ORL_H_WR2; // R12
			ORL_H_WR2: stateD = ORL_H_WR3; // R10
			ORL_H_WR3: stateD = ORL_H_WR4;
			ORL_H_WR4: stateD = ORL_H_IDLE;
			ORL_H_SINGLE: stateD = ORL_H_IDLE;
		endcase
	end

	// Port drive per state
	wire inWr = stateQ == ORL_H_WR2 || stateQ == ORL_H_WR3 || stateQ == ORL_H_WR4;
	wire [7:0] code2 = lowQ ? `ORL_P2_LOW : `ORL_P2_HIGH; // R7
	wire [7:0] code3 = lowQ ? `ORL_P3_LOW : `ORL_P3_HIGH; // R8
	wire [7:0] code4 = lowQ ? `ORL_P4_LOW : `ORL_P4_HIGH; // R9
	wire singleCfg = reqAddr == `ORL_ADDR_OVR_CONFIG;
	// Reserved config bits forced back to their default of zero
	wire [7:0] singleData = singleCfg ? (reqData & ~`ORL_CFG_RSVD_MASK) : reqData; // R4
	assign regs.wrEn = inWr || (stateQ == ORL_H_SINGLE && reqWrite);
	assign regs.rdEn = (stateQ == ORL_H_WAITINIT && !pollQ) || (stateQ == ORL_H_SINGLE && !reqWrite);
	assign regs.addr = stateQ == ORL_H_WR2 ? `ORL_ADDR_POWER_TWO :
		stateQ == ORL_H_WR3 ? `ORL_ADDR_POWER_THREE :
		stateQ == ORL_H_WR4 ? `ORL_ADDR_POWER_FOUR :
		stateQ == ORL_H_SINGLE ? reqAddr : `ORL_ADDR_INIT_STATUS;
	assign regs.wdata = stateQ == ORL_H_WR2 ? code2 :
		stateQ == ORL_H_WR3 ? code3 :
		stateQ == ORL_H_WR4 ? code4 : singleData;
	assign reqReady = stateQ == ORL_H_SINGLE;
	assign rspData = rspDataQ;
	assign rspValid = rspValidQ;
	assign initSeen = stateQ != ORL_H_WAITINIT;
	assign calNeeded = calNeededQ;
	// Enables forced off while the power group is rewritten
	assign calEnable = calEnableReq && !calNeededQ && stateQ == ORL_H_IDLE; // R11 R12
	assign serialLinkEnable = linkEnableReq && (stateQ == ORL_H_IDLE || stateQ == ORL_H_SINGLE); // R12

	////////////////////////////////////////////////////////////////////////
	// State and bookkeeping
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= ORL_H_WAITINIT;
			lowQ <= 1'b0;
			pollQ <= 1'b0;
		end else begin
			stateQ <= stateD;
			pollQ <= stateQ == ORL_H_WAITINIT && !pollQ; // one poll in flight
			if (stateQ == ORL_H_IDLE && modeReq) lowQ <= modeLow;
		end
	end

	// Read answers to the user and the calibration flag
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rspDataQ <= 8'h00;
			rspValidQ <= 1'b0;
			calNeededQ <= 1'b0;
		end else begin
			rspValidQ <= regs.rdValid && stateQ != ORL_H_WAITINIT;
			if (regs.rdValid) rspDataQ <= regs.rdata;
			if (stateQ == ORL_H_WR4) calNeededQ <= 1'b1; // R11
			else if (calDone) calNeededQ <= 1'b0;
		end
	end

endmodule : orl_host

`default_nettype wire

/* File: hw/orl_if.sv */
/*
  Register access carrier between host and converter register group.
  Assumes one clock shared by both ends; single-cycle write strobe,
  read data valid one cycle after the read strobe.
*/
`timescale 1ns/100ps
`default_nettype none

interface orl_if;
	logic [14:0] addr;
	logic [7:0] wdata;
	logic wrEn;
	logic rdEn;
	logic [7:0] rdata;
	logic rdValid;

	modport device (input addr, input wdata, input wrEn, input rdEn, output rdata, output rdValid);
	modport host (output addr, output wdata, output wrEn, output rdEn, input rdata, input rdValid);
endinterface : orl_if

`default_nettype wire

/* File: hw/orl_pkg.sv */
/*
  Types shared by both ends of the register group.
  Assumes orl_consts.svh on the include path.
*/
`include "orl_consts.svh"

package orl_pkg;
	// Operating mode decoded from the three power setting registers
	typedef enum logic [1:0] {
		ORL_MODE_LOW = 2'b01,
		ORL_MODE_HIGH = 2'b10,
		ORL_MODE_MIXED = 2'b00
	} orl_mode_t;

	// Host sequencer states
	typedef enum logic [6:0] {
		ORL_H_WAITINIT = 7'b000_0001,
		ORL_H_IDLE = 7'b000_0010,
		ORL_H_QUIESCE = 7'b000_0100,
		ORL_H_WR2 = 7'b000_1000,
		ORL_H_WR3 = 7'b001_0000,
		ORL_H_WR4 = 7'b010_0000,
		ORL_H_SINGLE = 7'b100_0000
	} orl_hstate_t;
endpackage : orl_pkg

/* File: tb/orl_asserts.sv */
/*
  Checker on the register carrier between host and converter ends.
  Assumes instantiation beside orl_if in the bench top, one clock.
*/
`timescale 1ns/100ps
`default_nettype none

module orl_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Carrier signals
	input wire logic [14:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [7:0] rdata,
	input wire logic rdValid
);
	logic [14:0] rdAddr_q;
	logic seen_q;

	// Last read address, and init-complete once returned to the host
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdAddr_q <= '0;
			seen_q <= 1'b0;
		end else begin
			rdAddr_q <= rdEn ? addr : rdAddr_q;
			seen_q <= seen_q | (rdValid && rdAddr_q == 15'h0270 && rdata[0]);
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// One power-group write on the carrier
	sequence s_wr(a, d);
		wrEn && addr == a && wdata == d;
	endsequence

	property p_rdLat; rdEn |=> rdValid; endproperty
	a_rdLat: assert property (p_rdLat) else $error("read answer late");
	property p_rdPulse; rdValid |-> $past(rdEn); endproperty
	a_rdPulse: assert property (p_rdPulse) else $error("read answer without strobe");
	property p_wrSeen; wrEn |-> seen_q; endproperty
	a_wrSeen: assert property (p_wrSeen) else $error("write before init complete");
	property p_rdSeen; rdEn && !seen_q |-> addr == 15'h0270; endproperty
	a_rdSeen: assert property (p_rdSeen) else $error("read before init complete");
	property p_initBits; rdValid && rdAddr_q == 15'h0270 |-> rdata[7:1] == 7'h00 && (!seen_q || rdata[0]); endproperty
	a_initBits: assert property (p_initBits) else $error("init status wrong");
	property p_cfgRsvd; wrEn && addr == 15'h0213 |-> wdata[7:4] == 4'h0; endproperty
	a_cfgRsvd: assert property (p_cfgRsvd) else $error("config reserved bits set");
	property p_lowSeq; s_wr(15'h029A, 8'h06) |=> s_wr(15'h029B, 8'h00) ##1 s_wr(15'h029C, 8'h14); endproperty
	a_lowSeq: assert property (p_lowSeq) else $error("low power group split");
	property p_highSeq; s_wr(15'h029A, 8'h0F) |=> s_wr(15'h029B, 8'h04) ##1 s_wr(15'h029C, 8'h1B); endproperty
	a_highSeq: assert property (p_highSeq) else $error("high perf group split");
endmodule : orl_asserts

`default_nettype wire

/* File: tb/tb_overrange_init_lowpower_regs.sv */
/*
  Self-checking bench: host and converter ends joined by orl_if.
  Assumes orl_pkg compiled first, orl_consts.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_overrange_init_lowpower_regs;
	import orl_pkg::*;
	localparam logic [35:0] HIT = {9'h000, 9'h080, 9'h180, 9'h07F};
	logic mclk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, modeReq = 0, modeLow = 0, calDone = 0, sampleEn = 0;
	logic calEnableReq = 1, linkEnableReq = 1, reqReady, rspValid, calEnable, serialLinkEnable, calNeeded, initSeen;
	logic [14:0] reqAddr = '0;
	logic [7:0] reqData = '0, rspData, rd;
	logic [35:0] samples = '0;
	logic [3:0] overrangeOut;
	orl_mode_t powerMode;
	int mismatches = 0, n_checks = 0, i, k, n;

	// Both ends face each other; short init count keeps the run brief
	orl_if regs ();
	orl_device #(.INIT_CYCLES(4)) orl_device_inst (.mclk(mclk), .rst_n(rst_n), .regs(regs),
		.sampleEn(sampleEn), .samples(samples), .overrangeOut(overrangeOut), .powerMode(powerMode));
	orl_host orl_host_inst (.mclk(mclk), .rst_n(rst_n), .regs(regs), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
		.modeReq(modeReq), .modeLow(modeLow), .calEnable(calEnable), .serialLinkEnable(serialLinkEnable),
		.calEnableReq(calEnableReq), .linkEnableReq(linkEnableReq), .calNeeded(calNeeded), .calDone(calDone),
		.initSeen(initSeen));
	orl_asserts orl_asserts_inst (.mclk(mclk), .rst_n(rst_n), .addr(regs.addr), .wdata(regs.wdata),
		.wrEn(regs.wrEn), .rdEn(regs.rdEn), .rdata(regs.rdata), .rdValid(regs.rdValid));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	// Enables must already be low when a power setting is written
	always @(posedge mclk) begin
		if (regs.wrEn === 1'b1 && regs.addr[14:4] === 11'h029 && (calEnable | serialLinkEnable) !== 1'b0) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, {calEnable, serialLinkEnable}, 2'h0);
		end
	end

	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// A bound that ran out ends the run
	task automatic hang(input logic ok);
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, ok, 1'b1);
			wrap_up();
		end
	endtask : hang

	// Request held until the edge that takes it; read data at rspValid
	task automatic acc(input logic w, input logic [14:0] a, input logic [7:0] d);
		@(posedge mclk);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		for (k = 0; k < 20 && reqReady !== 1'b1; k++) @(posedge mclk);
		hang(k < 20);
		reqValid <= 1'b0;
		if (!w) begin
			for (k = 0; k < 20 && rspValid !== 1'b1; k++) @(posedge mclk);
			hang(k < 20);
			rd = rspData;
		end
	endtask : acc

	task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(rd, e);
	endtask : rdchk

	// One sampling cycle; pins settled at the following low phase
	task automatic spl(input logic [35:0] s);
		@(posedge mclk);
		sampleEn <= 1'b1;
		samples <= s;
		@(posedge mclk);
		sampleEn <= 1'b0;
		samples <= '0;
		@(negedge mclk);
	endtask : spl

	task automatic mode(input logic low, input logic [7:0] e2, input logic [7:0] e3, input logic [7:0] e4,
		input orl_mode_t m);
		@(posedge mclk);
		modeReq <= 1'b1;
		modeLow <= low;
		@(posedge mclk);
		modeReq <= 1'b0;
		for (i = 0; i < 20 && calNeeded !== 1'b1; i++) @(posedge mclk);
		hang(i < 20);
		chk({7'h00, calEnable}, 8'h00);
		rdchk(15'h029A, e2);
		rdchk(15'h029B, e3);
		rdchk(15'h029C, e4);
		chk({6'h00, powerMode}, {6'h00, m});
		calDone <= 1'b1;
		@(posedge mclk);
		calDone <= 1'b0;
		for (i = 0; i < 20 && calNeeded !== 1'b0; i++) @(posedge mclk);
		hang(i < 20);
		chk({6'h00, calEnable, serialLinkEnable}, 8'h03);
	endtask : mode

	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 40 && initSeen !== 1'b1; i++) @(posedge mclk);
		hang(i < 40);
		rdchk(15'h0270, 8'h01);
		rdchk(15'h0211, 8'hF2);
		rdchk(15'h0213, 8'h07);
		rdchk(15'h029A, 8'h0F);
		rdchk(15'h029B, 8'h04);
		rdchk(15'h029C, 8'h1B);
		rdchk(15'h0200, 8'h00);
		chk({6'h00, powerMode}, {6'h00, ORL_MODE_HIGH});
		$display("Test reset values done");
		acc(1'b1, 15'h0211, 8'h80);
		rdchk(15'h0211, 8'h80);
		acc(1'b1, 15'h0213, 8'hF8);
		rdchk(15'h0213, 8'h08);
		for (n = 0; n < 2; n++) begin
			acc(1'b1, 15'h0213, 8'(8 + n));
			spl(HIT);
			chk({4'h0, overrangeOut}, 8'h06);
			for (i = 0; i < 40 && overrangeOut !== 4'h0; i++) spl('0);
			chk(8'(i >= (4 << n) && i <= (4 << n) + 1), 8'h01);
		end
		acc(1'b1, 15'h0213, 8'h07);
		spl(HIT);
		chk({4'h0, overrangeOut}, 8'h00);
		$display("Test over-range done");
		mode(1'b1, 8'h06, 8'h00, 8'h14, ORL_MODE_LOW);
		mode(1'b0, 8'h0F, 8'h04, 8'h1B, ORL_MODE_HIGH);
		$display("Test power modes done");
		wrap_up();
	end
endmodule : tb_overrange_init_lowpower_regs

`default_nettype wire
